// ---- design/sfts_pkg.sv ----
// Shared constants, types and carriers of the two-wire memory slave.
// Assumes: included before every design file that imports it.
package sfts_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int MEM_ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int SEL_W = 3;
  localparam int BIT_CNT_W = 3;

  // ----------------------------------------
  // Field positions, counts and reset values
  // ----------------------------------------
  localparam int ADDR_HI_LSB = 8;
  localparam int ADDR_HI_BITS = 5;
  localparam int PROT_LSB = 11;
  localparam logic [1:0] PROT_MSBS = 2'h3;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
  localparam logic [MEM_ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [MEM_ADDR_W-1:0] ADDR_STEP = 13'h0001;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // Bus phase of the slave
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_OUT,
    ST_TX,
    ST_ACK_IN
  } sfts_state_e;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    K_DEV,
    K_ADDR_HI,
    K_ADDR_LO,
    K_DATA
  } sfts_kind_e;

  // Slave address byte, bit 7 first
  typedef struct packed {
    logic [3:0] dev_type;
    logic [SEL_W-1:0] sel;
    logic rd;
  } sfts_slave_addr_s;

endpackage

// ---- design/sfts_sync.sv ----
// Two-stage level synchroniser for a bundle of independent bits.
// Assumes: each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/10ps

module sfts_sync
  import sfts_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Levels in and out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage read only by the second
  // Resets to the idle high of the pulled-up bus lines, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule // sfts_sync

// ---- design/sfts_slave.sv ----
// Two-wire serial slave front end with an 8192 x 8 memory array.
// Assumes: an external master drives the serial clock; the SDA wire is
// resolved outside from sda_oe_o with a pull-up.
`timescale 1ns/10ps

// Function
// - Answer only when select bits match pins
// - Sample on SCL rise, drive on fall
// - Pull SDA low or release, never high
// - Write protect high blocks top quarter only
// - Write protect low allows every location
// - Store 8192 bytes shifted serially
// - Take 16-bit address, decode low 13
// - Array write done before next transaction
// - Commit data byte right after transfer
// - Stop is SDA rising while SCL high
// - Stop abandons any pending operation
// - Start is SDA falling while SCL high
// - Start aborts and awaits new address
// - Slave only; master makes the clock
// - Internal reset brings interface to idle
// - Address byte: type, select, direction bits
// - Address counter increments, wraps to zero
// - Protected data unacknowledged, counter held
// - Reads continue while master acknowledges, MSB first
module sfts_slave
  import sfts_pkg::*;
#(
  // Device type code; the value is arbitrary
  parameter logic [3:0] DEV_TYPE = 4'h5
) (
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Two-wire link
  input wire logic scl_clk_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps
  input wire logic [SEL_W-1:0] device_select_pins_i,
  input wire logic wp_i
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic link_bit_r;
  logic scl_s;
  logic sda_s;
  logic bit_s;
  logic wp_s;
  logic [SEL_W-1:0] sel_s;
  logic scl_d_r;
  logic scl_dd_r;
  logic sda_d_r;
  logic sda_dd_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic oe_event;
  sfts_state_e state_r;
  sfts_kind_e kind_r;
  logic rd_mode_r;
  logic ack_phase_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BYTE_W-1:0] shift_r;
  logic sda_oe_r;
  logic sda_drv_r;
  logic [BYTE_W-1:0] rx_byte;
  logic [ADDR_HI_BITS-1:0] rx_hi5;
  sfts_slave_addr_s rx_addr;
  logic byte_done;
  logic prot_hit;
  logic rx_ack;
  logic wr_commit;
  logic tx_load;
  logic [MEM_ADDR_W-1:0] addr_r;
  logic [BYTE_W-1:0] mem_r [MEM_DEPTH];
  logic [BYTE_W-1:0] rd_data_r;

  // ----------------------------------------
  // Link clock domain
  // ----------------------------------------
  // Data bit caught on the SCL rising edge itself
  always_ff @(posedge scl_clk_i) begin
    link_bit_r <= sda_i;
  end

  // ----------------------------------------
  // Crossing and edge detection
  // ----------------------------------------
  // Bus lines and the caught bit into the core clock
  sfts_sync #(
    .WIDTH(3)
  ) u_bus_sync (
    .clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({scl_clk_i, sda_i, link_bit_r}),
    .q_o({scl_s, sda_s, bit_s})
  );

  // Slow straps into the core clock
  sfts_sync #(
    .WIDTH(SEL_W + 1)
  ) u_strap_sync (
    .clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({wp_i, device_select_pins_i}),
    .q_o({wp_s, sel_s})
  );

  // Delay line for edge detection; gives the caught bit a cycle of slack
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      scl_d_r <= 1'b1;
      scl_dd_r <= 1'b1;
      sda_d_r <= 1'b1;
      sda_dd_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      scl_dd_r <= scl_d_r;
      sda_d_r <= sda_s;
      sda_dd_r <= sda_d_r;
    end
  end

  // Bus events, all one cycle wide
  assign scl_rise = scl_d_r && !scl_dd_r;
  assign scl_fall = !scl_d_r && scl_dd_r;
  assign start_det = scl_d_r && scl_dd_r && sda_dd_r && !sda_d_r;
  assign stop_det = scl_d_r && scl_dd_r && !sda_dd_r && sda_d_r;
  assign oe_event = scl_fall || start_det || stop_det;

  // ----------------------------------------
  // Byte decode
  // ----------------------------------------
  // Completed byte, most significant bit first
  assign rx_byte = {shift_r[BYTE_W-2:0], bit_s};
  assign rx_hi5 = rx_byte[ADDR_HI_BITS-1:0];
  assign rx_addr = sfts_slave_addr_s'(rx_byte);
  assign byte_done = (state_r == ST_RX) && scl_rise && (bit_cnt_r == BIT_LAST);
  assign prot_hit = wp_s && (addr_r[MEM_ADDR_W-1:PROT_LSB] == PROT_MSBS);

  // Acknowledge decision for the byte just received
  always_comb begin
    case (kind_r)
      K_DEV: rx_ack = (rx_addr.dev_type == DEV_TYPE) && (rx_addr.sel == sel_s);
      K_DATA: rx_ack = !prot_hit;
      default: rx_ack = 1'b1;
    endcase
  end

  // Memory and counter strobes
  assign wr_commit = byte_done && (kind_r == K_DATA) && !prot_hit;
  assign tx_load = scl_fall && ack_phase_r &&
                   (((state_r == ST_ACK_OUT) && (kind_r == K_DEV) && rd_mode_r) ||
                    (state_r == ST_ACK_IN));

  // ----------------------------------------
  // Protocol state machine and SDA drive
  // ----------------------------------------
  // Start and Stop outrank every bit-level event
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      kind_r <= K_DEV;
      rd_mode_r <= 1'b0;
      ack_phase_r <= 1'b0;
      bit_cnt_r <= BIT_FIRST;
      shift_r <= '0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_RX;
      kind_r <= K_DEV;
      ack_phase_r <= 1'b0;
      bit_cnt_r <= BIT_FIRST;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      ack_phase_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise) begin
            shift_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == BIT_LAST) begin
              ack_phase_r <= 1'b0;
              if (kind_r == K_DEV) begin
                rd_mode_r <= rx_addr.rd;
              end
              if (rx_ack) begin
                state_r <= ST_ACK_OUT;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
        end
        ST_ACK_OUT: begin
          if (scl_fall) begin
            if (!ack_phase_r) begin
              ack_phase_r <= 1'b1;
              sda_oe_r <= 1'b1;
            end else begin
              ack_phase_r <= 1'b0;
              bit_cnt_r <= BIT_FIRST;
              if (tx_load) begin
                state_r <= ST_TX;
                shift_r <= rd_data_r;
                sda_oe_r <= ~rd_data_r[BYTE_W-1];
              end else begin
                state_r <= ST_RX;
                sda_oe_r <= 1'b0;
                case (kind_r)
                  K_DEV: kind_r <= K_ADDR_HI;
                  K_ADDR_HI: kind_r <= K_ADDR_LO;
                  default: kind_r <= K_DATA;
                endcase
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == BIT_LAST) begin
              state_r <= ST_ACK_IN;
              ack_phase_r <= 1'b0;
            end
          end else if (scl_fall) begin
            shift_r <= {shift_r[BYTE_W-2:0], 1'b0};
            sda_oe_r <= ~shift_r[BYTE_W-2];
          end
        end
        ST_ACK_IN: begin
          if (scl_rise) begin
            if (bit_s) begin
              state_r <= ST_IDLE;
            end else begin
              ack_phase_r <= 1'b1;
            end
          end else if (scl_fall) begin
            if (tx_load) begin
              state_r <= ST_TX;
              ack_phase_r <= 1'b0;
              bit_cnt_r <= BIT_FIRST;
              shift_r <= rd_data_r;
              sda_oe_r <= ~rd_data_r[BYTE_W-1];
            end else begin
              sda_oe_r <= 1'b0;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data level, low whenever enabled
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sda_drv_r <= 1'b0;
    end else begin
      sda_drv_r <= 1'b0;
    end
  end

  assign sda_o = sda_drv_r;
  assign sda_oe_o = sda_oe_r;

  // ----------------------------------------
  // Address latch
  // ----------------------------------------
  // Loaded by the address bytes, stepped per written or read data byte
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      addr_r <= ADDR_RST;
    end else if (byte_done && (kind_r == K_ADDR_HI)) begin
      addr_r <= {rx_hi5, addr_r[ADDR_HI_LSB-1:0]};
    end else if (byte_done && (kind_r == K_ADDR_LO)) begin
      addr_r <= {addr_r[MEM_ADDR_W-1:ADDR_HI_LSB], rx_byte};
    end else if (wr_commit || tx_load) begin
      addr_r <= addr_r + ADDR_STEP;
    end
  end

  // ----------------------------------------
  // Memory array
  // ----------------------------------------
  // Single-cycle write, so nothing is left busy for the next transaction
  always_ff @(posedge ref_clk_i) begin
    if (wr_commit) begin
      mem_r[addr_r] <= rx_byte;
    end
    rd_data_r <= mem_r[addr_r];
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_sda_only_low: assert property (sda_o == 1'b0)
    else $error("SDA driven high");
  a_oe_on_fall: assert property ($changed(sda_oe_r) |-> $past(oe_event))
    else $error("SDA drive changed away from an SCL fall");
  a_start_restart: assert property (start_det |=>
    (state_r == ST_RX) && (kind_r == K_DEV) && (bit_cnt_r == BIT_FIRST) && !sda_oe_r)
    else $error("Start did not ready a new address");
  a_start_edge: assert property ($fell(sda_d_r) && scl_d_r && scl_dd_r |=>
    state_r == ST_RX)
    else $error("Start edge missed");
  a_stop_edge: assert property ($rose(sda_d_r) && scl_d_r && scl_dd_r |=>
    state_r == ST_IDLE)
    else $error("Stop edge missed");
  a_stop_release: assert property (stop_det |=> !sda_oe_r [*2])
    else $error("Operation kept after Stop");
  a_sel_mismatch: assert property (byte_done && (kind_r == K_DEV) &&
    (rx_addr.sel != sel_s) |=> (state_r == ST_IDLE) && !sda_oe_r)
    else $error("Answered a foreign select code");
  a_dir_bit: assert property (byte_done && (kind_r == K_DEV) && rx_ack |=>
    (state_r == ST_ACK_OUT) && (rd_mode_r == $past(bit_s)))
    else $error("Direction bit not taken");
  a_hi_masked: assert property (byte_done && (kind_r == K_ADDR_HI) |=>
    addr_r[MEM_ADDR_W-1:ADDR_HI_LSB] == $past(rx_hi5))
    else $error("High address bits misdecoded");
  a_commit_ack: assert property (byte_done && (kind_r == K_DATA) && !prot_hit |=>
    (state_r == ST_ACK_OUT) && (addr_r == $past(addr_r) + ADDR_STEP))
    else $error("Data byte not committed");
  a_wp_lower: assert property (byte_done && (kind_r == K_DATA) && wp_s &&
    (addr_r[MEM_ADDR_W-1:PROT_LSB] != PROT_MSBS) |=> state_r == ST_ACK_OUT)
    else $error("Unprotected write refused");
  a_wp_off: assert property (byte_done && (kind_r == K_DATA) && !wp_s |->
    wr_commit ##1 (state_r == ST_ACK_OUT))
    else $error("Write refused with protection off");
  a_wp_block: assert property (byte_done && (kind_r == K_DATA) && prot_hit |->
    !wr_commit ##1 ((state_r == ST_IDLE) && $stable(addr_r)))
    else $error("Protected write taken");
  a_read_step: assert property (tx_load |=>
    (addr_r == $past(addr_r) + ADDR_STEP) && (shift_r == $past(rd_data_r)))
    else $error("Read byte or address step wrong");

  c_write_byte: cover property (wr_commit);
  c_read_byte: cover property (tx_load ##1 (state_r == ST_TX));
  c_start_abort: cover property ((state_r == ST_TX) ##1 start_det);
  c_wp_refuse: cover property (byte_done && (kind_r == K_DATA) && prot_hit);

endmodule // sfts_slave

// ---- testbench/sfts_master_model.sv ----
// Behavioural two-wire bus master used as the far side of the slave.
// Assumes: the bench resolves the wire from both open-drain enables.
`timescale 1ns/10ps

module sfts_master_model
  import sfts_pkg::*;
#(
  parameter int HALF = 12
) (
  // Pacing clock
  input wire logic ref_clk_i,
  // Resolved wire level
  input wire logic sda_i,
  // Master drives
  output logic scl_o,
  output logic sda_oe_o
);
  // Bus idles released, clock parked high
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Wait n core edges, then step off the edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // One bit; SDA moves only while SCL is low, the wire is sampled late in the high phase
  task automatic clk_bit(input logic b, output logic seen);
    wait_cyc(2);
    sda_oe_o = ~b;
    wait_cyc(HALF - 2);
    scl_o = 1'b1;
    wait_cyc(HALF - 2);
    seen = sda_i;
    wait_cyc(2);
    scl_o = 1'b0;
  endtask

  // Start from idle or as a repeated start
  task automatic start_cond();
    wait_cyc(2);
    sda_oe_o = 1'b0;
    wait_cyc(HALF);
    scl_o = 1'b1;
    wait_cyc(HALF);
    sda_oe_o = 1'b1;
    wait_cyc(HALF);
    scl_o = 1'b0;
  endtask

  // Stop while the master owns SDA; the clock then stands still high
  task automatic stop_cond();
    wait_cyc(2);
    sda_oe_o = 1'b1;
    wait_cyc(HALF);
    scl_o = 1'b1;
    wait_cyc(HALF);
    sda_oe_o = 1'b0;
    wait_cyc(HALF);
  endtask

  // First n bits of a byte, MSB first; a whole byte also clocks the ack slot
  task automatic put_bits(input logic [7:0] b, input int n, output logic ack);
    logic d;
    ack = 1'b0;
    for (int i = 0; i < n; i++) begin
      clk_bit(b[7-i], d);
    end
    if (n == 8) begin
      clk_bit(1'b1, d);
      ack = ~d;
    end
  endtask

  // Read a byte; acknowledge only when more bytes are wanted
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d);
      b[i] = d;
    end
    clk_bit(~more, d);
  endtask
endmodule // sfts_master_model

// ---- testbench/tb_serial_fram_two_wire_slave.sv ----
// Self-checking bench of the two-wire memory slave.
// Assumes: the master model paces itself from the core clock.
`timescale 1ns/10ps

module tb_serial_fram_two_wire_slave
  import sfts_pkg::*;
;
  // Device type code; the value is arbitrary
  localparam logic [3:0] DT = 4'hC;
  localparam logic [2:0] SEL = 3'h5;
  localparam int LIMIT = 60000;

  logic ref_clk, rst_b, scl, m_oe, d_oe, d_o, wp, scl_q, oe_q;
  logic [2:0] pins;
  logic sda;
  int err_total, checks, cyc;

  // Pull-up wire, wired-AND of both pull-downs
  assign sda = ~(m_oe | d_oe);

  sfts_slave #(.DEV_TYPE(DT)) dut_u (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b), .scl_clk_i(scl), .sda_i(sda),
    .sda_o(d_o), .sda_oe_o(d_oe), .device_select_pins_i(pins), .wp_i(wp));

  sfts_master_model #(.HALF(12)) m_u (
    .ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  // Core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pin watch: no change while SCL stays high, low-only drive, hang limit
  // Sampled on the falling edge, where the design's flops have settled
  always @(negedge ref_clk) begin
    scl_q <= scl;
    oe_q <= d_oe;
    cyc <= cyc + 1;
    if (rst_b && scl && scl_q) check({7'h0, d_oe}, {7'h0, oe_q});
    if (d_oe === 1'b1) check({7'h0, d_o}, 8'h00);
    if (cyc == LIMIT) begin
      err_total++;
      conclude();
    end
  end

  function automatic logic [7:0] sa_byte(input logic [2:0] s, input logic r);
    sfts_slave_addr_s sa;
    sa.dev_type = DT;
    sa.sel = s;
    sa.rd = r;
    return sa;
  endfunction

  // Start, write address byte, two memory address bytes
  task automatic addr_phase(input logic [15:0] a);
    logic ak;
    m_u.start_cond();
    m_u.put_bits(sa_byte(SEL, 1'b0), 8, ak);
    check({7'h0, ak}, 8'h01);
    m_u.put_bits(a[15:8], 8, ak);
    check({7'h0, ak}, 8'h01);
    m_u.put_bits(a[7:0], 8, ak);
    check({7'h0, ak}, 8'h01);
  endtask

  task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
    logic ak;
    m_u.put_bits(d, 8, ak);
    check({7'h0, ak}, {7'h0, exp_ack});
  endtask

  // (Repeated) start and read address
  task automatic rd_open();
    logic ak;
    m_u.start_cond();
    m_u.put_bits(sa_byte(SEL, 1'b1), 8, ak);
    check({7'h0, ak}, 8'h01);
  endtask

  task automatic rd_byte(input logic more, input logic [7:0] exp);
    logic [7:0] d;
    m_u.get_byte(more, d);
    check(d, exp);
  endtask

  // Every select code and a wrong type; only the strapped code answers
  task automatic t_select();
    logic ak;
    for (int s = 0; s < 8; s++) begin
      m_u.start_cond();
      m_u.put_bits(sa_byte(s[2:0], 1'b0), 8, ak);
      check({7'h0, ak}, {7'h0, s[2:0] == SEL});
      m_u.stop_cond();
    end
    m_u.start_cond();
    m_u.put_bits({~DT, SEL, 1'b0}, 8, ak);
    check({7'h0, ak}, 8'h00);
    m_u.stop_cond();
  endtask

  // Upper address bits ignored, counter wraps at the top
  task automatic t_wrap();
    addr_phase(16'hFFFE);
    wr_byte(8'h3C, 1'b1);
    wr_byte(8'hC3, 1'b1);
    wr_byte(8'h96, 1'b1);
    m_u.stop_cond();
    addr_phase(16'h1FFE);
    rd_open();
    rd_byte(1'b1, 8'h3C);
    rd_byte(1'b1, 8'hC3);
    rd_byte(1'b0, 8'h96);
    m_u.stop_cond();
  endtask

  // Protected quadrant refused, counter held, lower part still writable
  task automatic t_protect();
    addr_phase(16'h1800);
    wr_byte(8'h5A, 1'b1);
    m_u.stop_cond();
    wp = 1'b1;
    addr_phase(16'h17FF);
    wr_byte(8'h11, 1'b1);
    wr_byte(8'h22, 1'b0);
    m_u.stop_cond();
    rd_open();
    rd_byte(1'b0, 8'h5A);
    m_u.stop_cond();
    addr_phase(16'h17FF);
    rd_open();
    rd_byte(1'b1, 8'h11);
    rd_byte(1'b0, 8'h5A);
    m_u.stop_cond();
    wp = 1'b0;
  endtask

  // Partial bytes dropped by Stop and by Start
  task automatic t_abort();
    logic ak;
    addr_phase(16'h0010);
    wr_byte(8'hA5, 1'b1);
    m_u.stop_cond();
    addr_phase(16'h0010);
    m_u.put_bits(8'h00, 4, ak);
    m_u.stop_cond();
    addr_phase(16'h0010);
    m_u.put_bits(8'hFF, 5, ak);
    rd_open();
    rd_byte(1'b0, 8'hA5);
    m_u.stop_cond();
  endtask

  // Mid-run reset with the bus idle: address latch back to zero, memory kept
  task automatic t_reset();
    rst_b = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    check({7'h0, d_oe}, 8'h00);
    repeat (10) @(posedge ref_clk);
    #1;
    rd_open();
    rd_byte(1'b0, 8'h96);
    m_u.stop_cond();
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    wp = 1'b0;
    pins = SEL;
    err_total = 0;
    checks = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    check({7'h0, d_oe}, 8'h00);
    repeat (10) @(posedge ref_clk);
    #1;
    t_select();
    t_wrap();
    t_protect();
    t_abort();
    t_reset();
    conclude();
  end
endmodule // tb_serial_fram_two_wire_slave
